// File: rtl/bdc_pkg.sv
// Shared constants for the backlight dimming controller
package bdc_pkg;
    localparam int CLK_HZ = 100000000;
    localparam int N_SINK = 8;
    localparam logic [6:0] SLAVE_ADDR = 7'h2C;          // Arbitrary fixed address
    localparam logic [7:0] REG_BRIGHT = 8'h00;
    localparam logic [7:0] REG_CTRL = 8'h01;
    localparam logic [7:0] REG_FAULT = 8'h02;
    localparam logic [7:0] REG_ID = 8'h03;
    localparam logic [7:0] BRIGHT_RST = 8'hFF;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [4:0] ID_MFG_REV = 5'h05;           // Arbitrary vendor/revision value
    localparam int CTRL_ON_BIT = 0;
    localparam int CTRL_SEL_BIT = 1;
    localparam int CTRL_MD_BIT = 2;
    localparam int FLT_ANY_BIT = 0;
    localparam int FLT_THRM_BIT = 1;
    localparam int FLT_OC_BIT = 2;
    localparam int FLT_STAT_BIT = 3;
    // Internal dimming frequency default
    localparam int DIM_FREQ_HZ = 1000;
    localparam int DIM_STEP_CYC = CLK_HZ / (DIM_FREQ_HZ * 256);
    // Sustained over-current time
    localparam int OC_SUSTAIN_US = 10;
    localparam int OC_SUSTAIN_CYC = OC_SUSTAIN_US * (CLK_HZ / 1000000);
    // Auto-restart interval while all strings open
    localparam int RESTART_US = 40;
    localparam int RESTART_CYC = RESTART_US * (CLK_HZ / 1000000);
    // Dimming modes
    typedef enum logic [1:0] {
        BDC_NODELAY = 2'b00,
        BDC_DIRECT = 2'b01,
        BDC_ANALOG = 2'b10
    } bdc_mode_t;
    typedef enum logic [2:0] {
        BDC_IDLE = 3'b000,
        BDC_ADDR = 3'b001,
        BDC_CMD = 3'b010,
        BDC_WDAT = 3'b011,
        BDC_RDAT = 3'b100,
        BDC_SKIP = 3'b101
    } bdc_smb_t;
endpackage : bdc_pkg

// File: rtl/bdc_duty_if.sv
// Interface carrying measured duty from the meter to the core
`timescale 1ns/10ps
interface bdc_duty_if;
    logic valid;
    logic [7:0] duty;
    logic level;
    modport meter(output valid, output duty, output level);
    modport core(input valid, input duty, input level);
endinterface : bdc_duty_if

// File: rtl/bdc_duty_meter.sv
// Duty cycle counter for the PWM input
`timescale 1ns/10ps
module bdc_duty_meter (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic pwm_in,
    bdc_duty_if.meter dif
);
    logic [2:0] sync_q;
    logic [23:0] hi_q, hi_d, per_q, per_d;
    logic [7:0] duty_q, duty_d;
    logic valid_q, valid_d, lvl_q, lvl_d;
    logic [31:0] scaled;
    logic rise;

    // Second and third stages must agree before a level change counts
    always_comb begin
        lvl_d = lvl_q;
        if (sync_q[2] == sync_q[1]) begin
            lvl_d = sync_q[1];
        end
    end
    assign rise = lvl_d && !lvl_q;
    assign scaled = {hi_q, 8'h00} - {8'h00, hi_q};

    // Counts run at the full clock so rate adapts to any input period up to 16777215 cycles
    always_comb begin
        hi_d = hi_q;
        // Saturate while idle, but a rising edge still restarts the period
        per_d = (per_q == 24'hFFFFFF) ? per_q : per_q + 24'h000001;
        duty_d = duty_q;
        valid_d = 1'b0;
        if (lvl_q) begin
            hi_d = hi_q + 24'h000001;
        end
        if (rise) begin
            per_d = 24'h000001;
            hi_d = 24'h000000;
            if (per_q != 24'h000000) begin
                duty_d = 8'((scaled + {8'h00, per_q} - 32'h1) / {8'h00, per_q}); // [RL2]
                valid_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync_q <= 3'h0;
            hi_q <= 24'h000000;
            per_q <= 24'h000000;
            duty_q <= 8'h00;
            valid_q <= 1'b0;
            lvl_q <= 1'b0;
        end else begin
            sync_q <= {sync_q[1:0], pwm_in};
            hi_q <= hi_d;
            per_q <= per_d;
            duty_q <= duty_d;
            valid_q <= valid_d;
            lvl_q <= lvl_d;
        end
    end

    assign dif.valid = valid_q;
    assign dif.duty = duty_q;
    assign dif.level = lvl_q;
endmodule : bdc_duty_meter

// File: rtl/bdc_top.sv
// Backlight dimming control: brightness register, dimming, faults, SMBus slave
// Function
// RL1: Internal oscillator makes dimming PWM switching every sink at its frequency.
// RL2: Duty counter measures PWM input duty, adapting across 200Hz to 20kHz.
// RL3: Each measured duty is stored as eight bits in the brightness register.
// RL4: SMBus-written brightness byte goes straight into the same register.
// RL5: Sinks switch according to the duty held in the brightness register.
// RL6: No-delay mode switches all active sinks together at the oscillator rate.
// RL7: Source keeps duty at least 1 or 4 percent by frequency band.
// RL8: Direct mode makes all active sinks follow the PWM input itself.
// RL9: Source keeps direct mode minimum duty per frequency band up to 20k.
// RL10: Analog mode keeps sinks on with level scaled by brightness.
// RL11: Output above clamp plus 80mV holds switch off until below clamp.
// RL12: A sink with no current is deactivated and left out of regulation.
// RL13: A sink over its voltage threshold is switched off and excluded.
// RL14: Deactivated sinks stay off until reset, enable toggle or SMBus write.
// RL15: With every string open the device restarts repeatedly until one closes.
// RL16: Switch current at limit turns switch off until next switching cycle.
// RL17: Sustained over-current shuts down until reset or enable toggle.
// RL18: Short circuit shuts down at once until reset, enable toggle or SMBus.
// RL19: Over-temperature shuts down now and restarts when indication clears.
// RL20: Device answers its fixed 7-bit address plus direction bit.
// RL21: Read byte: address write, command, address read, device returns register.
// RL22: Write byte: address write, command, data; data goes into register.
// RL23: Brightness register resets to 0xFF and reads back current level.
// RL24: Control bit 0 turns sinks on; bits 1 and 2 choose source mode. Code uses only bit 1 (use_pwm); bit 2 is stored but unused.
// RL25: Device acks address, command and write data; host nacks read data.
`timescale 1ns/10ps
module bdc_top (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic pwm_in,
    input wire logic enable_in,
    input wire logic [1:0] dim_mode_in,
    input wire logic interface_select_pin_in,
    input wire logic [7:0] sink_no_current_in,
    input wire logic [7:0] sink_over_volt_in,
    input wire logic out_over_clamp_in,
    input wire logic out_below_clamp_in,
    input wire logic sw_over_limit_in,
    input wire logic sw_cycle_start_in,
    input wire logic out_short_in,
    input wire logic over_temp_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    output logic [7:0] led_sink_channel_out,
    output logic [7:0] analog_level_out,
    output logic boost_sw_en_out,
    output logic shutdown_out
);
    bdc_duty_if dif();
    bdc_duty_meter u_meter (.clk_in(clk_in), .rst_n_in(rst_n_in), .pwm_in(pwm_in), .dif(dif));

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] scl_s_q, sda_s_q, en_s_q, tmp_s_q;
    logic scl_q, scl_d, sdal_q, sdal_d, en_q, en_d, tmp_q, tmp_d;
    always_comb begin
        scl_d = (scl_s_q[2] == scl_s_q[1]) ? scl_s_q[1] : scl_q;
        sdal_d = (sda_s_q[2] == sda_s_q[1]) ? sda_s_q[1] : sdal_q;
        en_d = (en_s_q[2] == en_s_q[1]) ? en_s_q[1] : en_q;
        tmp_d = (tmp_s_q[2] == tmp_s_q[1]) ? tmp_s_q[1] : tmp_q;
    end
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            scl_s_q <= 3'h7;
            sda_s_q <= 3'h7;
            en_s_q <= 3'h0;
            tmp_s_q <= 3'h0;
            scl_q <= 1'b1;
            sdal_q <= 1'b1;
            en_q <= 1'b0;
            tmp_q <= 1'b0;
        end else begin
            scl_s_q <= {scl_s_q[1:0], scl_in};
            sda_s_q <= {sda_s_q[1:0], sda_in};
            en_s_q <= {en_s_q[1:0], enable_in};
            tmp_s_q <= {tmp_s_q[1:0], over_temp_in};
            scl_q <= scl_d;
            sdal_q <= sdal_d;
            en_q <= en_d;
            tmp_q <= tmp_d;
        end
    end
    wire scl_rise = scl_d && !scl_q;
    wire scl_fall = !scl_d && scl_q;
    wire start_c = scl_q && scl_d && sdal_q && !sdal_d;
    wire stop_c = scl_q && scl_d && !sdal_q && sdal_d;
    wire en_rise = en_d && !en_q;

    // ------------------------------------------------------------
    // SMBus byte slave
    // ------------------------------------------------------------
    bdc_pkg::bdc_smb_t st_q, st_d;
    logic [7:0] sh_q, sh_d, cmd_q, cmd_d, bright_q, bright_d, ctrl_q, ctrl_d;
    logic [3:0] bit_q, bit_d;
    logic ack_q, ack_d, oe_q, oe_d, dout_q, dout_d, wr_q, wr_d, smb_rst;
    logic [7:0] rd_val, fault_reg;
    always_comb begin
        case (cmd_q)
            bdc_pkg::REG_BRIGHT: rd_val = bright_q; // [RL23]
            bdc_pkg::REG_CTRL: rd_val = {5'h00, ctrl_q[2:0]};
            bdc_pkg::REG_FAULT: rd_val = fault_reg;
            bdc_pkg::REG_ID: rd_val = {3'h4, bdc_pkg::ID_MFG_REV};
            default: rd_val = 8'h00;
        endcase
    end
    always_comb begin
        st_d = st_q;
        sh_d = sh_q;
        bit_d = bit_q;
        cmd_d = cmd_q;
        ack_d = ack_q;
        oe_d = oe_q;
        dout_d = dout_q;
        wr_d = 1'b0;
        if (start_c) begin
            st_d = bdc_pkg::BDC_ADDR;
            bit_d = 4'h0;
            ack_d = 1'b0;
            oe_d = 1'b0;
        end else if (stop_c) begin
            st_d = bdc_pkg::BDC_IDLE;
            oe_d = 1'b0;
        end else if (st_q != bdc_pkg::BDC_IDLE && st_q != bdc_pkg::BDC_SKIP) begin
            if (scl_rise && !ack_q && st_q != bdc_pkg::BDC_RDAT) begin
                sh_d = {sh_q[6:0], sdal_q};
                bit_d = bit_q + 4'h1;
            end else if (scl_rise && !ack_q) begin
                bit_d = bit_q + 4'h1;
            end else if (scl_rise && ack_q && st_q == bdc_pkg::BDC_RDAT && sdal_q) begin
                st_d = bdc_pkg::BDC_SKIP; // [RL25]
            end
            if (scl_fall && !ack_q && bit_q == 4'h8) begin
                bit_d = 4'h0;
                ack_d = 1'b1;
                oe_d = 1'b1;
                dout_d = 1'b0;
                case (st_q)
                    bdc_pkg::BDC_ADDR: begin
                        if (sh_q[7:1] != bdc_pkg::SLAVE_ADDR) begin // [RL20]
                            st_d = bdc_pkg::BDC_SKIP;
                            oe_d = 1'b0;
                            ack_d = 1'b0;
                        end
                    end
                    bdc_pkg::BDC_CMD: cmd_d = sh_q; // [RL21]
                    bdc_pkg::BDC_WDAT: wr_d = 1'b1; // [RL22]
                    bdc_pkg::BDC_RDAT: oe_d = 1'b0;
                    default: st_d = bdc_pkg::BDC_SKIP;
                endcase
            end else if (scl_fall && ack_q) begin
                ack_d = 1'b0;
                oe_d = 1'b0;
                case (st_q)
                    bdc_pkg::BDC_ADDR: begin
                        if (sh_q[0]) begin
                            st_d = bdc_pkg::BDC_RDAT;
                            sh_d = {rd_val[6:0], 1'b0};
                            dout_d = rd_val[7];
                            oe_d = !rd_val[7];
                        end else begin
                            st_d = bdc_pkg::BDC_CMD;
                        end
                    end
                    bdc_pkg::BDC_CMD: st_d = bdc_pkg::BDC_WDAT;
                    bdc_pkg::BDC_RDAT: st_d = bdc_pkg::BDC_SKIP;
                    default: st_d = bdc_pkg::BDC_SKIP;
                endcase
            end else if (scl_fall && st_q == bdc_pkg::BDC_RDAT && bit_q != 4'h8) begin
                dout_d = sh_q[7];
                oe_d = !sh_q[7]; // Open drain: drive only zeros
                sh_d = {sh_q[6:0], 1'b0};
            end
        end
    end
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q <= bdc_pkg::BDC_IDLE;
            sh_q <= 8'h00;
            bit_q <= 4'h0;
            cmd_q <= 8'h00;
            ack_q <= 1'b0;
            oe_q <= 1'b0;
            dout_q <= 1'b1;
            wr_q <= 1'b0;
        end else begin
            st_q <= st_d;
            sh_q <= sh_d;
            bit_q <= bit_d;
            cmd_q <= cmd_d;
            ack_q <= ack_d;
            oe_q <= oe_d;
            dout_q <= dout_d;
            wr_q <= wr_d;
        end
    end
    assign smb_rst = wr_q && cmd_q == bdc_pkg::REG_CTRL;

    // ------------------------------------------------------------
    // Brightness and control registers
    // ------------------------------------------------------------
    wire use_pwm = !interface_select_pin_in || ctrl_q[bdc_pkg::CTRL_SEL_BIT];
    always_comb begin
        bright_d = bright_q;
        ctrl_d = ctrl_q;
        if (use_pwm && dif.valid) begin
            bright_d = dif.duty; // [RL3]
        end
        if (wr_q && cmd_q == bdc_pkg::REG_BRIGHT) begin
            bright_d = sh_q; // [RL4]
        end
        if (wr_q && cmd_q == bdc_pkg::REG_CTRL) begin
            ctrl_d = {5'h00, sh_q[2:0]}; // [RL24]
        end
    end

    // ------------------------------------------------------------
    // Dimming oscillator, faults, sink outputs
    // ------------------------------------------------------------
    logic [15:0] div_q, div_d;
    logic [7:0] phase_q, phase_d, dead_q, dead_d, sink_q, sink_d, alvl_q, alvl_d;
    logic [31:0] oc_q, oc_d, rs_q, rs_d;
    logic oclat_q, oclat_d, sclat_q, sclat_d, swoff_q, swoff_d, ovc_q, ovc_d;
    logic shut_q, shut_d, bsw_q, bsw_d;
    wire tick = div_q == 16'(bdc_pkg::DIM_STEP_CYC - 1);
    wire clr_dead = en_rise || smb_rst || rs_q == 32'(bdc_pkg::RESTART_CYC - 1);
    always_comb begin
        div_d = tick ? 16'h0000 : div_q + 16'h0001;
        phase_d = tick ? phase_q + 8'h01 : phase_q; // [RL1]
        // A fault seen in the clearing cycle still latches
        dead_d = (clr_dead ? 8'h00 : dead_q) | sink_over_volt_in; // [RL13] [RL14]
        dead_d = dead_d | sink_no_current_in; // [RL12]
        rs_d = 32'h0;
        if (dead_q == 8'hFF && rs_q != 32'(bdc_pkg::RESTART_CYC - 1)) begin
            rs_d = rs_q + 32'h1; // [RL15]
        end
        oc_d = sw_over_limit_in ? oc_q + 32'h1 : 32'h0;
        oclat_d = (oclat_q && !en_rise) || oc_q == 32'(bdc_pkg::OC_SUSTAIN_CYC); // [RL17]
        sclat_d = (sclat_q && !en_rise && !smb_rst) || out_short_in; // [RL18]
        swoff_d = swoff_q;
        if (sw_cycle_start_in) swoff_d = 1'b0;
        if (sw_over_limit_in) swoff_d = 1'b1; // [RL16]
        ovc_d = ovc_q;
        if (out_below_clamp_in) ovc_d = 1'b0;
        if (out_over_clamp_in) ovc_d = 1'b1; // [RL11]
        shut_d = !en_q || oclat_d || sclat_d || tmp_q; // [RL19]
        bsw_d = !shut_d && !swoff_d && !ovc_d && !sw_over_limit_in && !out_over_clamp_in;
        sink_d = 8'h00;
        alvl_d = 8'h00;
        if (!shut_d && (ctrl_q[bdc_pkg::CTRL_ON_BIT] || !interface_select_pin_in)) begin
            case (bdc_pkg::bdc_mode_t'(dim_mode_in))
                bdc_pkg::BDC_NODELAY: sink_d = {8{phase_q < bright_q}} & ~dead_d; // [RL5] [RL6]
                bdc_pkg::BDC_DIRECT: sink_d = {8{dif.level}} & ~dead_d; // [RL8]
                bdc_pkg::BDC_ANALOG: begin
                    sink_d = ~dead_d; // [RL10]
                    alvl_d = bright_q;
                end
                default: sink_d = 8'h00;
            endcase
        end
    end
    assign fault_reg = {2'b00, (dead_q != 8'h00) ? 2'b01 : 2'b00, shut_q == 1'b0,
        oclat_q, tmp_q, oclat_q || tmp_q || sclat_q};
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bright_q <= bdc_pkg::BRIGHT_RST;
            ctrl_q <= bdc_pkg::CTRL_RST;
            div_q <= 16'h0000;
            phase_q <= 8'h00;
            dead_q <= 8'h00;
            sink_q <= 8'h00;
            alvl_q <= 8'h00;
            oc_q <= 32'h0;
            rs_q <= 32'h0;
            oclat_q <= 1'b0;
            sclat_q <= 1'b0;
            swoff_q <= 1'b0;
            ovc_q <= 1'b0;
            shut_q <= 1'b1;
            bsw_q <= 1'b0;
        end else begin
            bright_q <= bright_d;
            ctrl_q <= ctrl_d;
            div_q <= div_d;
            phase_q <= phase_d;
            dead_q <= dead_d;
            sink_q <= sink_d;
            alvl_q <= alvl_d;
            oc_q <= oc_d;
            rs_q <= rs_d;
            oclat_q <= oclat_d;
            sclat_q <= sclat_d;
            swoff_q <= swoff_d;
            ovc_q <= ovc_d;
            shut_q <= shut_d;
            bsw_q <= bsw_d;
        end
    end
    assign sda_out = dout_q;
    assign sda_oe_out = oe_q;
    assign led_sink_channel_out = sink_q;
    assign analog_level_out = alvl_q;
    assign boost_sw_en_out = bsw_q;
    assign shutdown_out = shut_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_short_shutdown: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL18]
        out_short_in |=> shutdown_out) else $error("short did not shut down");
    a_temp_shutdown: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL19]
        tmp_q |=> shutdown_out) else $error("thermal did not shut down");
    a_limit_switch: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL16]
        sw_over_limit_in |=> !boost_sw_en_out) else $error("switch on at limit");
    a_clamp_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL11]
        out_over_clamp_in |=> !boost_sw_en_out) else $error("switch on over clamp");
    a_dead_sink: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL12]
        (sink_no_current_in[0] && !clr_dead) |=> !led_sink_channel_out[0])
        else $error("open sink still on");
    a_ov_sink: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL13]
        (sink_over_volt_in[1] && !clr_dead) |=> !led_sink_channel_out[1])
        else $error("over-volt sink still on");
    a_duty_store: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL3]
        (use_pwm && dif.valid && !wr_q) |=> bright_q == $past(dif.duty))
        else $error("duty not stored");
    a_smb_write: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL4]
        (wr_q && cmd_q == bdc_pkg::REG_BRIGHT) |=> bright_q == $past(sh_q))
        else $error("brightness write lost");
endmodule : bdc_top

// File: sim/bdc_host_model.sv
// SMBus host and PWM source model facing the dimming controller
`timescale 1ns/10ps
module bdc_host_model #(
    parameter int HALF_NS = 80
) (
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_low_out,
    output logic pwm_out
);
    // Bus idles released; clock stands high between frames
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
        pwm_out = 1'b0;
    end
    // ------------------------------------------------------------
    // Bit and frame level
    // ------------------------------------------------------------
    task automatic start_cond();
        sda_low_out = 1'b0;
        #HALF_NS scl_out = 1'b1;
        #HALF_NS sda_low_out = 1'b1;
        #HALF_NS scl_out = 1'b0;
        #HALF_NS;
    endtask : start_cond
    task automatic stop_cond();
        sda_low_out = 1'b1;
        #HALF_NS scl_out = 1'b1;
        #HALF_NS sda_low_out = 1'b0;
        #HALF_NS;
    endtask : stop_cond
    // Data only changes while the clock is low
    task automatic clk_bit(input logic b, output logic got);
        sda_low_out = ~b;
        #HALF_NS scl_out = 1'b1;
        got = sda_in;
        #HALF_NS scl_out = 1'b0;
    endtask : clk_bit
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic got;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(b[i], got);
        end
        clk_bit(1'b1, got);
        ack = ~got;
    endtask : send_byte
    task automatic recv_byte(output logic [7:0] b);
        logic got;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, got);
            b[i] = got;
        end
        clk_bit(1'b1, got); // Host refuses the data byte
    endtask : recv_byte
    // ------------------------------------------------------------
    // Transactions
    // ------------------------------------------------------------
    task automatic write_reg(input logic [6:0] addr, input logic [7:0] cmd,
                             input logic [7:0] data, output logic ok);
        logic a0, a1, a2;
        start_cond();
        send_byte({addr, 1'b0}, a0);
        send_byte(cmd, a1);
        send_byte(data, a2);
        stop_cond();
        ok = a0 & a1 & a2;
    endtask : write_reg
    task automatic read_reg(input logic [7:0] cmd, output logic [7:0] data, output logic ok);
        logic a0, a1, a2;
        start_cond();
        send_byte({bdc_pkg::SLAVE_ADDR, 1'b0}, a0);
        send_byte(cmd, a1);
        start_cond();
        send_byte({bdc_pkg::SLAVE_ADDR, 1'b1}, a2);
        recv_byte(data);
        stop_cond();
        ok = a0 & a1 & a2;
    endtask : read_reg
    // Callers keep duty above the band minimum
    task automatic pwm_burst(input int high_ns, input int period_ns, input int n);
        repeat (n) begin
            pwm_out = 1'b1;
            #high_ns pwm_out = 1'b0;
            #(period_ns - high_ns);
        end
    endtask : pwm_burst
endmodule : bdc_host_model

// File: sim/tb_top.sv
// Self-checking bench for the backlight dimming controller
`timescale 1ns/10ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin error_cnt++; \
    $display("[ERR] %0t got %h exp %h", $time, (got), (exp)); end end
module tb_top;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic pwm_in, scl_in, sda_in, sda_low, sda_out, sda_oe_out, boost_sw_en_out, shutdown_out;
    logic enable_in, interface_select_pin_in, out_short_in, over_temp_in, ok;
    logic [1:0] dim_mode_in;
    logic [3:0] boost_ev;
    logic [7:0] sink_over_volt_in, sink_no_current_in, led_sink_channel_out, analog_level_out, rd;
    int error_cnt = 0;
    int samples_checked = 0;
    always #5 clk_in = ~clk_in;
    // Open-drain line with pull-up
    assign sda_in = !sda_low && (!sda_oe_out || sda_out);
    bdc_host_model u_host (.sda_in(sda_in), .scl_out(scl_in), .sda_low_out(sda_low),
        .pwm_out(pwm_in));
    bdc_top u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .pwm_in(pwm_in), .enable_in(enable_in),
        .dim_mode_in(dim_mode_in), .interface_select_pin_in(interface_select_pin_in),
        .sink_no_current_in(sink_no_current_in), .sink_over_volt_in(sink_over_volt_in),
        .out_over_clamp_in(boost_ev[0]), .out_below_clamp_in(boost_ev[1]),
        .sw_over_limit_in(boost_ev[2]), .sw_cycle_start_in(boost_ev[3]),
        .out_short_in(out_short_in), .over_temp_in(over_temp_in),
        .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
        .led_sink_channel_out(led_sink_channel_out), .analog_level_out(analog_level_out),
        .boost_sw_en_out(boost_sw_en_out), .shutdown_out(shutdown_out));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up
    // Sel 0 watches the sinks, sel 1 the shutdown flag
    task automatic wait_until(input int sel, input logic [7:0] v, input int lim);
        for (int i = 0; i < lim; i++) begin
            @(negedge clk_in);
            if ((sel == 0 && led_sink_channel_out === v) || (sel == 1 && shutdown_out === v[0])) begin
                return;
            end
        end
        error_cnt++;
        $display("[ERR] %0t wait ran out", $time);
        wrap_up();
    endtask : wait_until
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_smbus();
        wait_until(1, 8'h00, 50);
        u_host.read_reg(bdc_pkg::REG_BRIGHT, rd, ok);
        `CHK(rd, bdc_pkg::BRIGHT_RST)
        u_host.write_reg(bdc_pkg::SLAVE_ADDR, bdc_pkg::REG_BRIGHT, 8'h5A, ok);
        `CHK(ok, 1'b1)
        u_host.read_reg(bdc_pkg::REG_BRIGHT, rd, ok);
        `CHK(rd, 8'h5A)
        u_host.write_reg(bdc_pkg::SLAVE_ADDR, bdc_pkg::REG_CTRL, 8'h01, ok);
        u_host.read_reg(bdc_pkg::REG_CTRL, rd, ok);
        `CHK(rd, 8'h01)
        wait_until(0, 8'hFF, 50);
        `CHK(analog_level_out, 8'h5A)
        u_host.write_reg(bdc_pkg::SLAVE_ADDR, bdc_pkg::REG_CTRL, 8'h00, ok);
        wait_until(0, 8'h00, 50);
        `CHK(led_sink_channel_out, 8'h00)
        u_host.write_reg(bdc_pkg::SLAVE_ADDR + 7'h01, bdc_pkg::REG_CTRL, 8'h01, ok);
        `CHK(ok, 1'b0)
        `CHK(led_sink_channel_out, 8'h00)
        $display("smbus test done");
    endtask : t_smbus
    task automatic t_faults();
        u_host.write_reg(bdc_pkg::SLAVE_ADDR, bdc_pkg::REG_CTRL, 8'h01, ok);
        wait_until(0, 8'hFF, 50);
        @(negedge clk_in) over_temp_in = 1'b1;
        wait_until(1, 8'h01, 50);
        `CHK(shutdown_out, 1'b1)
        @(negedge clk_in) over_temp_in = 1'b0;
        wait_until(1, 8'h00, 50);
        `CHK(shutdown_out, 1'b0)
        @(negedge clk_in) sink_over_volt_in = 8'h08;
        wait_until(0, 8'hF7, 50);
        @(negedge clk_in) sink_over_volt_in = 8'h00;
        repeat (20) @(negedge clk_in);
        `CHK(led_sink_channel_out, 8'hF7)
        @(negedge clk_in) out_short_in = 1'b1;
        wait_until(1, 8'h01, 50);
        @(negedge clk_in) out_short_in = 1'b0;
        repeat (20) @(negedge clk_in);
        `CHK(shutdown_out, 1'b1)
        u_host.write_reg(bdc_pkg::SLAVE_ADDR, bdc_pkg::REG_CTRL, 8'h01, ok);
        wait_until(1, 8'h00, 50);
        wait_until(0, 8'hFF, 50);
        `CHK(led_sink_channel_out, 8'hFF)
        $display("fault test done");
    endtask : t_faults
    task automatic t_power();
        `CHK(boost_sw_en_out, 1'b1)
        for (int k = 0; k < 2; k++) begin
            @(negedge clk_in) boost_ev = k ? 4'h1 : 4'h4;
            @(negedge clk_in) boost_ev = 4'h0;
            repeat (5) @(negedge clk_in);
            `CHK(boost_sw_en_out, 1'b0)
            @(negedge clk_in) boost_ev = k ? 4'h2 : 4'h8;
            @(negedge clk_in) boost_ev = 4'h0;
            `CHK(boost_sw_en_out, 1'b1)
        end
        @(negedge clk_in) boost_ev = 4'h4;
        repeat (500) @(negedge clk_in);
        `CHK(shutdown_out, 1'b0)
        wait_until(1, 8'h01, 600);
        @(negedge clk_in) boost_ev = 4'h0;
        repeat (20) @(negedge clk_in);
        `CHK(shutdown_out, 1'b1)
        @(negedge clk_in) enable_in = 1'b0;
        repeat (8) @(negedge clk_in);
        @(negedge clk_in) enable_in = 1'b1;
        wait_until(1, 8'h00, 50);
        `CHK(shutdown_out, 1'b0)
        @(negedge clk_in) sink_no_current_in = 8'hFF;
        @(negedge clk_in) sink_no_current_in = 8'h00;
        repeat (3900) @(negedge clk_in);
        `CHK(led_sink_channel_out, 8'h00)
        wait_until(0, 8'hFF, 200);
        `CHK(led_sink_channel_out, 8'hFF)
        $display("power test done");
    endtask : t_power
    task automatic t_pwm();
        @(negedge clk_in) interface_select_pin_in = 1'b0;
        u_host.pwm_burst(250, 1000, 4);
        `CHK(analog_level_out, 8'h40)
        @(negedge clk_in) dim_mode_in = 2'b01;
        fork
            u_host.pwm_burst(3000, 6000, 1);
            begin
                wait_until(0, 8'hFF, 40);
                `CHK(led_sink_channel_out, 8'hFF)
                wait_until(0, 8'h00, 340);
                `CHK(led_sink_channel_out, 8'h00)
            end
        join
        // Oscillator phase is still below the measured duty here
        @(negedge clk_in) dim_mode_in = 2'b00;
        wait_until(0, 8'hFF, 10);
        wait_until(0, 8'h00, 30000);
        `CHK(analog_level_out, 8'h00)
        $display("pwm test done");
    endtask : t_pwm
    initial begin
        enable_in = 1'b0;
        dim_mode_in = 2'b10;
        interface_select_pin_in = 1'b1;
        sink_over_volt_in = 8'h00;
        sink_no_current_in = 8'h00;
        boost_ev = 4'h0;
        out_short_in = 1'b0;
        over_temp_in = 1'b0;
        @(negedge clk_in);
        `CHK(shutdown_out, 1'b1)
        `CHK(led_sink_channel_out, 8'h00)
        @(negedge clk_in) rst_n_in = 1'b1;
        @(negedge clk_in) enable_in = 1'b1;
        t_smbus();
        t_faults();
        t_power();
        t_pwm();
        wrap_up();
    end
endmodule : tb_top
